//--- cdio_core.sv
// Register shell: Avalon-MM slave, accumulator, status, watchdog and file registers.
// Assumes a single 125 MHz clock; one waitrequest cycle per access.
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
`include "cdio_defines.svh"
`default_nettype none
module cdio_core (
    input  wire logic                    ref_clk,       // 125 MHz clock
    input  wire logic                    sys_rst,       // Async reset, high
    input  wire logic [`CDIO_ADDR_W-1:0] avs_address,   // Byte address
    input  wire logic                    avs_read,      // Read request
    input  wire logic                    avs_write,     // Write request
    input  wire logic [31:0]             avs_writedata, // Write data
    input  wire logic [3:0]              avs_byteenable,// Byte lanes
    output logic [31:0]                  avs_readdata,  // Read data
    output logic                         avs_waitrequest,// Stall
    output logic [7:0]                   accum,         // Accumulator
    output logic                         expiry_flag,   // Watchdog expiry flag
    output logic                         sleep_flag     // Sleep flag
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]  fileMem [`CDIO_FILE_DEPTH];
    logic        ack;
    logic [3:0]  status;
    logic [7:0]  watchdog_counter;
    logic [7:0]  prescale;
    logic        acc;
    logic        wrInstr;
    logic        wrAccum;
    logic        wrStatus;
    logic        fileHit;
    logic [6:0]  fileIdx;
    logic [6:0]  opIdx;
    logic [31:0] next_readdata;
    cdio_exec_if ex ();

    cdio_decoder u_decoder (
        .ex (ex.decoder)
    );

    function automatic logic hit(input logic [`CDIO_ADDR_W-1:0] a,
                                 input logic [`CDIO_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: every access waits exactly one cycle, then completes.
    assign acc             = avs_read | avs_write;
    assign avs_waitrequest = acc & ~ack;
    assign wrInstr  = avs_write & ack & hit(avs_address, `CDIO_OFS_INSTR)
                      & avs_byteenable[0] & avs_byteenable[1];
    assign wrAccum  = avs_write & ack & hit(avs_address, `CDIO_OFS_ACCUM)
                      & avs_byteenable[0];
    assign wrStatus = avs_write & ack & hit(avs_address, `CDIO_OFS_STATUS)
                      & avs_byteenable[0];
    assign fileHit  = (avs_address[9] == 1'b1);
    assign fileIdx  = avs_address[8:2];
    assign opIdx    = avs_writedata[6:0];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= acc & ~ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Execution happens at the edge that completes the instruction write.
    assign ex.opcode  = avs_writedata[13:0];
    assign ex.operand = fileMem[opIdx];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            accum <= `CDIO_ACCUM_RST;
        end else if (wrInstr && ex.toAccum) begin
            accum <= ex.result; // RULE_01 RULE_03 RULE_04
        end else if (wrAccum) begin
            accum <= avs_writedata[7:0];
        end
    end

    // File memory has no reset; contents undefined until written.
    always_ff @(posedge ref_clk) begin
        if (wrInstr && ex.toFile) begin
            fileMem[opIdx] <= ex.result; // RULE_03 RULE_04
        end else if (avs_write && ack && fileHit && avs_byteenable[0]) begin
            fileMem[fileIdx] <= avs_writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status: bus writes and opcode effects never meet in one cycle.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status <= `CDIO_STATUS_RST;
        end else if (wrStatus) begin
            status <= avs_writedata[3:0];
        end else if (wrInstr) begin
            if (ex.updZero) begin
                status[`CDIO_ST_ZERO] <= (ex.result == 8'h00); // RULE_01 RULE_03 RULE_04
            end
            if (ex.kick) begin
                status[`CDIO_ST_EXPIRY] <= 1'b1; // RULE_02
                status[`CDIO_ST_SLEEP]  <= 1'b1; // RULE_02
            end
            if (ex.op == cdio_pkg::OP_NONE) begin
                status[`CDIO_ST_BADOP] <= 1'b1;
            end
        end
    end
    assign expiry_flag = status[`CDIO_ST_EXPIRY];
    assign sleep_flag  = status[`CDIO_ST_SLEEP];

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: prescaler wraps into the counter; counter saturates.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prescale         <= 8'h00;
            watchdog_counter <= 8'h00;
        end else if (wrInstr && ex.kick) begin
            prescale         <= 8'h00; // RULE_02
            watchdog_counter <= 8'h00; // RULE_02
        end else begin
            prescale <= prescale + 8'h01;
            if (prescale == `CDIO_PRE_MAX && watchdog_counter != 8'hff) begin
                watchdog_counter <= watchdog_counter + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero.
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (hit(avs_address, `CDIO_OFS_ACCUM)) begin
            next_readdata = {24'h000000, accum};
        end else if (hit(avs_address, `CDIO_OFS_STATUS)) begin
            next_readdata = {28'h0000000, status};
        end else if (hit(avs_address, `CDIO_OFS_WDOG)) begin
            next_readdata = {16'h0000, prescale, watchdog_counter};
        end else if (fileHit) begin
            next_readdata = {24'h000000, fileMem[fileIdx]};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            avs_readdata <= next_readdata;
        end
    end
endmodule : cdio_core
`default_nettype wire

//--- cdio_core_checker.sv
// Checker for the opcode effects of cdio_core, watching its ports only.
// Assumes a bind onto cdio_core and cdio_defines.svh on the include path.
`timescale 1ns/10ps
`include "cdio_defines.svh"
`default_nettype none
module cdio_core_checker (
    input wire logic        ref_clk,         // Clock
    input wire logic        sys_rst,         // Async reset
    input wire logic [9:0]  avs_address,     // Byte address
    input wire logic        avs_write,       // Write request
    input wire logic [31:0] avs_writedata,   // Write data
    input wire logic [3:0]  avs_byteenable,  // Byte lanes
    input wire logic        avs_waitrequest, // Stall
    input wire logic [7:0]  accum,           // Accumulator
    input wire logic        expiry_flag,     // Expiry flag
    input wire logic        sleep_flag       // Sleep flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic        ex;
    logic [13:0] op;
    // Opcode runs on the completing edge of an instruction write
    assign ex = avs_write && !avs_waitrequest && avs_address == `CDIO_OFS_INSTR
                && avs_byteenable[1:0] == 2'b11;
    assign op = avs_writedata[13:0];
    ////////////////////////////////////////////////////////////////////////
    property p_clracc; ex && op[13:7] == 7'h02 |=> accum == 8'h00; endproperty
    a_clracc: assert property (p_clracc) else $error("accumulator not cleared");
    property p_kick; ex && op == 14'h0064 |=> expiry_flag && sleep_flag; endproperty
    a_kick: assert property (p_kick) else $error("kick left a flag low");
    // File-bound results must leave the accumulator and one flag port alone (sleep for decrement, expiry for invert)
    property p_decr; ex && op[13:7] == 7'h07 |=> $stable(accum) && $stable(sleep_flag);
    endproperty
    a_decr: assert property (p_decr) else $error("decrement to file moved state");
    property p_inv; ex && op[13:7] == 7'h13 |=> $stable(accum) && $stable(expiry_flag);
    endproperty
    a_inv: assert property (p_inv) else $error("invert to file moved state");
    c_kick: cover property (ex && op == 14'h0064);
    c_decr: cover property (ex && op[13:8] == 6'h03 && !op[7]);
    c_inv: cover property (ex && op[13:8] == 6'h09 && !op[7]);
endmodule : cdio_core_checker
bind cdio_core cdio_core_checker u_chk (.ref_clk, .sys_rst, .avs_address, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_waitrequest, .accum, .expiry_flag, .sleep_flag);
`default_nettype wire

//--- cdio_decoder.sv
// Pure combinational decode and execute of the four opcodes.
// Assumes the shell supplies the addressed file register value on operand.
`timescale 1ns/10ps
`include "cdio_defines.svh"
`default_nettype none
module cdio_decoder (
    cdio_exec_if.decoder ex  // Opcode in, result out
);
    always_comb begin
        ex.op      = cdio_pkg::OP_NONE;
        ex.result  = 8'h00;
        ex.toAccum = 1'b0;
        ex.toFile  = 1'b0;
        ex.updZero = 1'b0;
        ex.kick    = 1'b0;
        if (ex.opcode == `CDIO_OP_KICK) begin
            ex.op   = cdio_pkg::OP_KICK;
            ex.kick = 1'b1; // RULE_02
        end else if (ex.opcode[13:7] == `CDIO_OP7_CLRACC) begin
            // Low seven bits ignored
            ex.op      = cdio_pkg::OP_CLRACC;
            ex.result  = 8'h00;
            ex.toAccum = 1'b1; // RULE_01
            ex.updZero = 1'b1; // RULE_01
        end else if (ex.opcode[13:8] == `CDIO_OP6_DECR) begin
            ex.op      = cdio_pkg::OP_DECR;
            ex.result  = ex.operand - 8'h01; // RULE_03
            ex.toAccum = ~ex.opcode[`CDIO_DEST_BIT]; // RULE_03
            ex.toFile  = ex.opcode[`CDIO_DEST_BIT]; // RULE_03
            ex.updZero = 1'b1; // RULE_03
        end else if (ex.opcode[13:8] == `CDIO_OP6_INVERT) begin
            ex.op      = cdio_pkg::OP_INVERT;
            ex.result  = ~ex.operand; // RULE_04
            ex.toAccum = ~ex.opcode[`CDIO_DEST_BIT]; // RULE_04
            ex.toFile  = ex.opcode[`CDIO_DEST_BIT]; // RULE_04
            ex.updZero = 1'b1; // RULE_04
        end
    end
endmodule : cdio_decoder
`default_nettype wire

//--- cdio_defines.svh
// Offsets, field positions, reset values and timing for the clear/decrement/invert unit.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one word for each register.
// Contract
// (RULE_01) Clear-accumulator opcode zeroes accumulator and sets zero flag in one cycle.
// (RULE_02) Watchdog-kick opcode clears counter and prescaler, sets expiry and sleep flags.
// (RULE_03) Decrement opcode subtracts one from file register, updates zero, d selects target.
// (RULE_04) Invert opcode complements file register, updates zero, d selects target.
`ifndef CDIO_DEFINES_SVH
`define CDIO_DEFINES_SVH

`define CDIO_ADDR_W        10
`define CDIO_OFS_INSTR     10'h000
`define CDIO_OFS_ACCUM     10'h004
`define CDIO_OFS_STATUS    10'h008
`define CDIO_OFS_WDOG      10'h00c
`define CDIO_OFS_FILE      10'h200
`define CDIO_FILE_DEPTH    128

`define CDIO_ST_ZERO       0
`define CDIO_ST_EXPIRY     1
`define CDIO_ST_SLEEP      2
`define CDIO_ST_BADOP      3

`define CDIO_ACCUM_RST     8'h00
`define CDIO_STATUS_RST    4'h6
`define CDIO_PRE_MAX       8'hff

`define CDIO_OP_KICK       14'h0064
`define CDIO_OP7_CLRACC    7'h02
`define CDIO_OP6_DECR      6'h03
`define CDIO_OP6_INVERT    6'h09
`define CDIO_DEST_BIT      7

`endif

//--- cdio_exec_if.sv
// Carrier between the register shell and the opcode decoder.
// Assumes both sides sit in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
interface cdio_exec_if;
    logic [13:0]          opcode;   // Instruction word
    logic [7:0]           operand;  // Addressed file register value
    cdio_pkg::cdio_op_type op;      // Decoded operation
    logic [7:0]           result;   // Value to write back
    logic                 toAccum;  // Result goes to accumulator
    logic                 toFile;   // Result goes to file register
    logic                 updZero;  // Zero flag takes result==0
    logic                 kick;     // Watchdog restart
    modport shell   (output opcode, operand,
                     input op, result, toAccum, toFile, updZero, kick);
    modport decoder (input opcode, operand,
                     output op, result, toAccum, toFile, updZero, kick);
endinterface : cdio_exec_if
`default_nettype wire

//--- cdio_pkg.sv
// Types shared by the clear/decrement/invert unit.
// Assumes cdio_defines.svh is included by its users for the constants.
`default_nettype none
package cdio_pkg;
    typedef enum logic [2:0] {
        OP_NONE, OP_CLRACC, OP_KICK, OP_DECR, OP_INVERT
    } cdio_op_type;
endpackage : cdio_pkg
`default_nettype wire

//--- clear_decrement_invert_ops_test.sv
// Self-checking bench for cdio_core: random opcodes with corner operands.
// Assumes cdio_core and its checker are compiled beside it.
`timescale 1ns/10ps
`include "cdio_defines.svh"
`default_nettype none
module clear_decrement_invert_ops_test;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [9:0]  avs_address = 10'h000, fa;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        avs_waitrequest, expiry_flag, sleep_flag, dbit, eZ, kk;
    logic [7:0]  accum, v, a, res, eAcc, eFile;
    logic [13:0] opc;
    logic [6:0]  idx;
    int          n_errors = 0, samples_checked = 0, cycles = 0, k;
    always #4 ref_clk = ~ref_clk;
    cdio_core dut (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .accum, .expiry_flag,
        .sleep_flag);
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (n_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    // Request held up to the edge that sees waitrequest low; read data taken there
    task automatic bus(input logic wr, input logic [9:0] ad, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= ad;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    function automatic logic [7:0] calc(input int op, input logic [7:0] x);
        return (op == 2) ? x - 8'h01 : ~x;
    endfunction : calc
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 30000) begin
            n_errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hd093));
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        bus(1'b0, `CDIO_OFS_STATUS, 32'h0);
        chk("status reset", 32'h6, q);
        for (int it = 0; it < 100; it++) begin
            // First four cover decrement to zero, underflow, all ones and top bit
            k = (it < 4) ? 2 + it / 2 : $urandom % 5;
            v = (it < 4) ? 8'(32'h80ff0001 >> (8 * it)) : 8'($urandom);
            a = 8'($urandom);
            dbit = 1'($urandom);
            idx = 7'($urandom);
            fa = `CDIO_OFS_FILE + {1'b0, idx, 2'b00};
            case (k)
                0: opc = {`CDIO_OP7_CLRACC, 7'($urandom)};
                1: opc = `CDIO_OP_KICK;
                2: opc = {`CDIO_OP6_DECR, dbit, idx};
                4: opc = 14'h3fff;
                default: opc = {`CDIO_OP6_INVERT, dbit, idx};
            endcase
            bus(1'b1, fa, {24'h0, v});
            bus(1'b1, `CDIO_OFS_ACCUM, {24'h0, a});
            bus(1'b1, `CDIO_OFS_STATUS, 32'h0);
            bus(1'b1, `CDIO_OFS_INSTR, {18'h0, opc});
            kk = (k == 1);
            if (kk) begin
                bus(1'b0, `CDIO_OFS_WDOG, 32'h0);
                chk("wdog count", 32'h0, {24'h0, q[7:0]});
                chk("wdog prescaler low", 32'h1, {31'h0, q[15:8] < 8'h10});
            end
            res = calc(k, v);
            eAcc = (k == 0) ? 8'h00 : a;
            eFile = v;
            eZ = (k == 0);
            if (k == 2 || k == 3) begin
                if (dbit) eFile = res;
                else eAcc = res;
                eZ = (res == 8'h00);
            end
            // Ports settle after the executing edge
            @(negedge ref_clk);
            chk("accum port", {24'h0, eAcc}, {24'h0, accum});
            chk("flag ports", {30'h0, kk, kk}, {30'h0, expiry_flag, sleep_flag});
            bus(1'b0, fa, 32'h0);
            chk("file reg", {24'h0, eFile}, q);
            bus(1'b0, `CDIO_OFS_STATUS, 32'h0);
            chk("status", {28'h0, k == 4, kk, kk, eZ}, q);
        end
        end_of_test();
    end
endmodule : clear_decrement_invert_ops_test
`default_nettype wire
